// ==== csl_defs.vh ====
// Constants for the clock stop and strap latch block
`ifndef CSL_DEFS_VH
`define CSL_DEFS_VH
`define CSL_N_CPU 4
`define CSL_N_BUS 6
`define CSL_N_STRAP 5
`define CSL_CPU_HALF 2
`define CSL_BUS_HALF 4
`define CSL_DIV_CW 4
`define CSL_CLK_MHZ 10
`define CSL_PWRUP_TIME_US 3000
`define CSL_PWRUP_CYC 16'h7530
`define CSL_TMR_W 16
`define CSL_ST_WAIT 2'h0
`define CSL_ST_HOLD 2'h1
`define CSL_ST_RUN 2'h2
`endif

// ==== csl_sync.v ====
// Two-flop synchroniser for pin inputs
module csl_sync #(
	parameter W = 1
) (
	input wire clock,
	input wire arst_n,
	input wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= {W{1'b0}};
			sync_r <= {W{1'b0}};
		end else begin
			meta_r <= d;
			sync_r <= meta_r;
		end
	end

	assign q = sync_r;
endmodule // csl_sync

// ==== csl_div.v ====
// Clock divider with a flag for the last low cycle
module csl_div #(
	parameter HALF = 2,
	parameter CW = 4
) (
	input wire clock,
	input wire arst_n,
	output wire level,
	output wire rise_next
);
	localparam integer LAST_I = HALF - 1;
	localparam [CW-1:0] LAST = LAST_I[CW-1:0];
	reg [CW-1:0] cnt_r;
	reg level_r;

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= {CW{1'b0}};
			level_r <= 1'b0;
		end else if (cnt_r == LAST) begin
			cnt_r <= {CW{1'b0}};
			level_r <= ~level_r;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	assign level = level_r;
	// High on the cycle before the level rises
	assign rise_next = (cnt_r == LAST) && !level_r;
endmodule // csl_div

// ==== csl_clock_stop_latch.v ====
// Clock halt gating and power-up strap latch
`include "csl_defs.vh"
module csl_clock_stop_latch #(
	parameter N_CPU = `CSL_N_CPU,
	parameter N_BUS = `CSL_N_BUS,
	parameter N_STRAP = `CSL_N_STRAP,
	parameter CPU_HALF = `CSL_CPU_HALF,
	parameter BUS_HALF = `CSL_BUS_HALF,
	parameter [`CSL_TMR_W-1:0] PWRUP_CYC = `CSL_PWRUP_CYC
) (
	input wire clock,
	input wire arst_n,
	input wire cpu_halt_n,
	input wire bus_halt_n,
	input wire supply_ok,
	input wire [N_STRAP-1:0] strap_pin_in,
	output reg [N_CPU-1:0] cpu_clk_out_r,
	output reg [N_BUS-1:0] gated_bus_clock_outputs_r,
	output reg free_running_bus_clock_r,
	output reg [N_STRAP-1:0] strap_pin_out_r,
	output reg [N_STRAP-1:0] strap_pin_oe_n_r,
	output reg [N_STRAP-1:0] strap_cfg_r,
	output reg clocks_running_r
);
	localparam [`CSL_TMR_W-1:0] TMR_ONE = {{(`CSL_TMR_W-1){1'b0}}, 1'b1};
	localparam [`CSL_TMR_W-1:0] TMR_LAST = PWRUP_CYC - TMR_ONE;

	wire cpu_halt_n_s;
	wire bus_halt_n_s;
	wire supply_ok_s;
	wire [N_STRAP-1:0] strap_s;
	wire cpu_lvl;
	wire cpu_rise;
	wire bus_lvl;
	wire bus_rise;

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [`CSL_TMR_W-1:0] tmr_r;
	reg cpu_en_r;
	reg bus_en_r;
	reg fr_en_r;
	reg [`CSL_TMR_W-1:0] tmr_nxt;
	reg cpu_en_nxt;
	reg bus_en_nxt;
	reg fr_en_nxt;
	reg running_nxt;
	reg taken_r;
	wire capture_now;
	wire timer_done;
	wire cpu_gate;
	wire bus_gate;
	wire fr_gate;
	genvar gi;

	// One synchroniser per control pin
	csl_sync #(.W(1)) u_sync_cpu (
		.clock(clock),
		.arst_n(arst_n),
		.d(cpu_halt_n),
		.q(cpu_halt_n_s)
	);

	csl_sync #(.W(1)) u_sync_bus (
		.clock(clock),
		.arst_n(arst_n),
		.d(bus_halt_n),
		.q(bus_halt_n_s)
	);

	csl_sync #(.W(1)) u_sync_supply (
		.clock(clock),
		.arst_n(arst_n),
		.d(supply_ok),
		.q(supply_ok_s)
	);

	// Pins are released while sampled so the pull-up gives one
	csl_sync #(.W(N_STRAP)) u_sync_strap (
		.clock(clock),
		.arst_n(arst_n),
		.d(strap_pin_in),
		.q(strap_s)
	);

	csl_div #(.HALF(CPU_HALF), .CW(`CSL_DIV_CW)) u_div_cpu (
		.clock(clock),
		.arst_n(arst_n),
		.level(cpu_lvl),
		.rise_next(cpu_rise)
	);

	csl_div #(.HALF(BUS_HALF), .CW(`CSL_DIV_CW)) u_div_bus (
		.clock(clock),
		.arst_n(arst_n),
		.level(bus_lvl),
		.rise_next(bus_rise)
	);

	// Power-up sequence
	always @* begin
		state_nxt = state_r;
		case (state_r)
			`CSL_ST_WAIT: begin
				if (supply_ok_s) begin
					state_nxt = `CSL_ST_HOLD;
				end
			end
			`CSL_ST_HOLD: begin
				if (timer_done) begin
					state_nxt = `CSL_ST_RUN;
				end
			end
			`CSL_ST_RUN: begin
				state_nxt = `CSL_ST_RUN;
			end
			default: begin
				state_nxt = `CSL_ST_WAIT;
			end
		endcase
	end

	// Capture and expiry strobes
	assign capture_now = (state_r == `CSL_ST_WAIT) && supply_ok_s && !taken_r;
	assign timer_done = (state_r == `CSL_ST_HOLD) && (tmr_r == TMR_LAST);

	// Sequencer state
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= `CSL_ST_WAIT;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Sticky mark, so a state upset cannot recapture
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			taken_r <= 1'b0;
		end else if (capture_now) begin
			taken_r <= 1'b1;
		end
	end

	// Power-up timer counts only while holding
	always @* begin
		tmr_nxt = tmr_r;
		if (state_r == `CSL_ST_HOLD) begin
			tmr_nxt = tmr_r + TMR_ONE;
		end
	end

	// Timer register
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tmr_r <= {`CSL_TMR_W{1'b0}};
		end else begin
			tmr_r <= tmr_nxt;
		end
	end

	// Clocks run once the timer has expired
	always @* begin
		running_nxt = 1'b0;
		if (state_nxt == `CSL_ST_RUN) begin
			running_nxt = 1'b1;
		end
	end

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			clocks_running_r <= 1'b0;
		end else begin
			clocks_running_r <= running_nxt;
		end
	end

	// Enables change only just before a rise, so no runt pulses
	always @* begin
		cpu_en_nxt = cpu_en_r;
		if (cpu_rise) begin
			cpu_en_nxt = clocks_running_r & cpu_halt_n_s;
		end
	end

	always @* begin
		bus_en_nxt = bus_en_r;
		if (bus_rise) begin
			bus_en_nxt = clocks_running_r & bus_halt_n_s;
		end
	end

	always @* begin
		fr_en_nxt = fr_en_r;
		if (bus_rise) begin
			fr_en_nxt = clocks_running_r;
		end
	end

	// Enable registers
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cpu_en_r <= 1'b0;
		end else begin
			cpu_en_r <= cpu_en_nxt;
		end
	end

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			bus_en_r <= 1'b0;
		end else begin
			bus_en_r <= bus_en_nxt;
		end
	end

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fr_en_r <= 1'b0;
		end else begin
			fr_en_r <= fr_en_nxt;
		end
	end

	// Divider levels gated by their enables
	assign cpu_gate = cpu_lvl & cpu_en_r;
	assign bus_gate = bus_lvl & bus_en_r;
	assign fr_gate = bus_lvl & fr_en_r;

	// Processor clocks, parked low when halted
	generate
		for (gi = 0; gi < N_CPU; gi = gi + 1) begin : g_cpu
			always @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					cpu_clk_out_r[gi] <= 1'b0;
				end else begin
					cpu_clk_out_r[gi] <= cpu_gate;
				end
			end
		end
	endgenerate

	// Gated bus clocks, parked low when halted
	generate
		for (gi = 0; gi < N_BUS; gi = gi + 1) begin : g_bus
			always @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					gated_bus_clock_outputs_r[gi] <= 1'b0;
				end else begin
					gated_bus_clock_outputs_r[gi] <= bus_gate;
				end
			end
		end
	endgenerate

	// Free-running bus clock
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			free_running_bus_clock_r <= 1'b0;
		end else begin
			free_running_bus_clock_r <= fr_gate;
		end
	end

	// Strap configuration, taken once
	generate
		for (gi = 0; gi < N_STRAP; gi = gi + 1) begin : g_strap_cfg
			always @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					strap_cfg_r[gi] <= 1'b0;
				end else if (capture_now) begin
					strap_cfg_r[gi] <= strap_s[gi];
				end
			end
		end
	endgenerate

	// Dual pins become outputs after capture
	generate
		for (gi = 0; gi < N_STRAP; gi = gi + 1) begin : g_strap_oe
			always @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					strap_pin_oe_n_r[gi] <= 1'b1;
				end else if (capture_now) begin
					strap_pin_oe_n_r[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Dual pins low until the clocks run
	generate
		for (gi = 0; gi < N_STRAP; gi = gi + 1) begin : g_strap_out
			always @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					strap_pin_out_r[gi] <= 1'b0;
				end else begin
					strap_pin_out_r[gi] <= fr_gate;
				end
			end
		end
	endgenerate
endmodule // csl_clock_stop_latch

// ==== csl_chk_assertions.sv ====
// Checker for clock halt gating and strap latch
module csl_chk (input wire clock,
	input wire arst_n,
	input wire cpu_halt_n,
	input wire bus_halt_n,
	input wire [3:0] cpu_clk_out_r,
	input wire [5:0] gated_bus_clock_outputs_r,
	input wire free_running_bus_clock_r,
	input wire [4:0] strap_pin_oe_n_r,
	input wire [4:0] strap_cfg_r,
	input wire clocks_running_r);
	timeunit 1ns / 1ns;
	wire [3:0] c = cpu_clk_out_r;
	wire f = free_running_bus_clock_r;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	property p_cs; !cpu_halt_n [*8] |-> c == 4'h0; endproperty
	a_cs: assert property (p_cs) else $error("cpu not parked");
	property p_cr; (cpu_halt_n && clocks_running_r) [*8] |-> ##[0:3] c[0]; endproperty
	a_cr: assert property (p_cr) else $error("cpu not back");
	property p_cw; $rose(c[0]) |-> (c == 4'hf) [*2] ##1 c == 4'h0; endproperty
	a_cw: assert property (p_cw) else $error("cpu pulse cut");
	property p_fw; $rose(f) |-> f [*4] ##1 !f [*4]; endproperty
	a_fw: assert property (p_fw) else $error("free clock cut");
	property p_bg; $rose(f) |-> gated_bus_clock_outputs_r == ($past(bus_halt_n) ? 6'h3f : 6'h0);
	endproperty
	a_bg: assert property (p_bg) else $error("bus gate late");
	property p_bl; !f |-> gated_bus_clock_outputs_r == 6'h0; endproperty
	a_bl: assert property (p_bl) else $error("bus not low");
	property p_kp; !strap_pin_oe_n_r[0] |=> $stable(strap_cfg_r) && strap_pin_oe_n_r == 5'h0; endproperty
	a_kp: assert property (p_kp) else $error("straps moved");
	property p_go; $rose(f) |-> clocks_running_r; endproperty
	a_go: assert property (p_go) else $error("early clock");
	cover property (!bus_halt_n && $rose(f));
	cover property ($rose(cpu_halt_n) && clocks_running_r);
	cover property ($fell(strap_pin_oe_n_r[0]));
endmodule // csl_chk

// ==== csl_chipset.sv ====
// Chipset model moving halt pins at free clock rise
module csl_chipset (input wire free_clk,
	input wire cpu_req_n,
	input wire bus_req_n,
	output reg cpu_halt_n = 1'h1,
	output reg bus_halt_n = 1'h1);
	timeunit 1ns / 1ns;
	always @(posedge free_clk) begin
		cpu_halt_n <= cpu_req_n;
		bus_halt_n <= bus_req_n;
	end
endmodule // csl_chipset

// ==== csl_clock_stop_latch_tb_top.sv ====
// Bench for clock halt gating and strap latch
module csl_clock_stop_latch_tb_top;
	timeunit 1ns / 1ns;
	reg clock = 0, arst_n = 0, supply_ok = 0, cpu_req_n = 1, bus_req_n = 1;
	wire cpu_halt_n, bus_halt_n, free_running_bus_clock_r, clocks_running_r;
	wire [3:0] cpu_clk_out_r;
	wire [5:0] gated_bus_clock_outputs_r;
	wire [4:0] strap_pin_out_r, strap_pin_oe_n_r, strap_cfg_r;
	wire [4:0] strap_pin_in = strap_pin_oe_n_r & 5'h1a | ~strap_pin_oe_n_r & strap_pin_out_r;
	integer failures = 0, samples_checked = 0, nc, ng, nf, np;
	csl_clock_stop_latch #(.PWRUP_CYC(16'h0014)) i_dut (.*);
	csl_chipset i_cs (.*, .free_clk(free_running_bus_clock_r));
	initial forever #50 clock = ~clock;
	initial begin
		repeat (1000) @(posedge clock);
		failures++;
		final_report;
	end
	task chk(input string s, input [63:0] v, e);
		samples_checked++;
		failures += (v !== e);
		if (v !== e) $display("ERROR %s exp %h seen %h", s, e, v);
	endtask
	task run;
		repeat (24) @(posedge clock);
		{nc, ng, nf, np} = 128'h0;
		repeat (16) begin
			@(posedge clock) #1 nc += cpu_clk_out_r[0];
			ng += gated_bus_clock_outputs_r[0];
			nf += free_running_bus_clock_r;
			np += strap_pin_out_r[0];
		end
	endtask
	task t_cap;
		@(posedge clock) supply_ok <= 1;
		repeat (3) @(posedge clock);
		#1 chk("cfg", {strap_cfg_r, strap_pin_oe_n_r, strap_pin_out_r}, 15'h6800);
		repeat (19) @(posedge clock);
		#1 chk("run", clocks_running_r, 1'h0);
		@(posedge clock) supply_ok <= 0;
		#1 chk("run", clocks_running_r, 1'h1);
		$display("cap done");
	endtask
	task t_halt;
		@(posedge clock) cpu_req_n <= 0;
		run;
		chk("cpu bus", {nc, ng}, {32'h0, 32'h8});
		chk("free pin", {nf, np}, {32'h8, 32'h8});
		@(posedge clock) {cpu_req_n, bus_req_n} <= 2'h2;
		run;
		chk("cpu bus", {nc, ng}, {32'h8, 32'h0});
		chk("free pin", {nf, np}, {32'h8, 32'h8});
		chk("cfg", strap_cfg_r, 5'h1a);
		$display("halt done");
	endtask
	initial begin
		repeat (6) @(posedge clock);
		arst_n <= 1;
		t_cap;
		t_halt;
		final_report;
	end
	task final_report;
		$display("checked %0d failed %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
endmodule // csl_clock_stop_latch_tb_top
bind csl_clock_stop_latch csl_chk i_chk (.*);
